// >>> verilog/isr_params.svh
// isr_params.svh: bit positions, error codes and reset values of the status sets
// assumes: included by bare name into the design modules
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH

// standard event bits
`define ISR_OPERATION_COMPLETE_FLAG 0
`define ISR_QUERY_ERROR_FLAG 2
`define ISR_BACKED_MEMORY_ERROR_FLAG 3
`define ISR_EXECUTION_ERROR_FLAG 4
`define ISR_DEVICE_DEPENDENT_ERROR_FLAG 5
`define ISR_USER_REQUEST_FLAG 6
`define ISR_POWER_ON_FLAG 7

// operation set bits
`define ISR_OPER_MEASURING 4
`define ISR_OPER_WAIT_TRIGGER 5
`define ISR_OPER_FILTER_SETTLED 8
`define ISR_OPER_IDLE 10

// measurement set bits
`define ISR_READING_OVERFLOW_FLAG 0
`define ISR_LOW_LIMIT_ONE_FLAG 1
`define ISR_HIGH_LIMIT_ONE_FLAG 2
`define ISR_LOW_LIMIT_TWO_FLAG 3
`define ISR_HIGH_LIMIT_TWO_FLAG 4
`define ISR_READING_AVAILABLE_FLAG 5
`define ISR_BUFFER_NOTIFY_FLAG 6
`define ISR_BUFFER_AVAILABLE_FLAG 7
`define ISR_BUFFER_HALF_FLAG 8
`define ISR_BUFFER_FULL_FLAG 9
`define ISR_BUFFER_WRAP_FLAG 10
`define ISR_HARDWARE_LIMIT_FLAG 11
`define ISR_BUFFER_QUARTER_FLAG 12
`define ISR_BUFFER_THREE_QUARTER_FLAG 13
`define ISR_ANY_LIMIT_FLAG 14

// questionable set bits
`define ISR_QUES_TEMPERATURE 4
`define ISR_QUES_CALIBRATION 8
`define ISR_QUES_COMMAND_WARNING 14

// error codes that map onto standard event bits
`define ISR_ERR_DATA_LOST 10'h204
`define ISR_ERR_SCAN_RESUME 10'h205
`define ISR_ERR_SETUP_MISMATCH 10'h208
`define ISR_ERR_CARD_HARDWARE 10'h20b
`define ISR_ERR_CARD_UNSUPPORTED 10'h20c

// misc values
`define ISR_EVENT_RESET 16'h0000
`define ISR_COND_RESET 16'h0000
`define ISR_MIN_BUFFERED 16'h0002
`define ISR_COMPLETE_REPLY 16'h0001

`endif

// >>> verilog/isr_pkg.sv
// isr_pkg: command codes and state types of the status register sets
// assumes: isr_params.svh is reachable on the include path
package isr_pkg;

    // host command codes; unused codes answer nothing
    typedef enum logic [3:0] {
        CMD_NONE = 4'b0000,
        CMD_READ_STD_EVENT = 4'b0001,
        CMD_READ_OPER_EVENT = 4'b0010,
        CMD_READ_MEAS_EVENT = 4'b0011,
        CMD_READ_QUES_EVENT = 4'b0100,
        CMD_READ_OPER_COND = 4'b0101,
        CMD_READ_MEAS_COND = 4'b0110,
        CMD_READ_QUES_COND = 4'b0111,
        CMD_CLEAR_STATUS = 4'b1000,
        CMD_STATUS_PRESET = 4'b1001,
        CMD_COMPLETE_QUERY = 4'b1010
    } isr_cmd_t;

    // state of one event latch
    typedef struct packed {
        logic [15:0] latch;
    } isr_latch_st_t;

    // state of the top block
    typedef struct packed {
        logic [15:0] operCond;
        logic [15:0] measCond;
        logic [15:0] quesCond;
        logic completeWait;
        logic powerOnPend;
        logic calSampled;
        logic calBad;
        logic respValid;
        logic [15:0] respData;
        logic sumStd;
        logic sumOper;
        logic sumMeas;
        logic sumQues;
        logic errLamp;
    } isr_main_st_t;

endpackage : isr_pkg

// >>> verilog/isr_event_latch.sv
// isr_event_latch: sixteen sticky event bits with read-clear and clear-all
// assumes: set and clear strobes are one-cycle pulses in the clk_sys domain
`timescale 1ns/10ps
`include "isr_params.svh"

module isr_event_latch (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] setBits,
    input wire logic readClr,
    input wire logic clrAll,
    output logic [15:0] latch
);

    isr_pkg::isr_latch_st_t st_r;
    isr_pkg::isr_latch_st_t st_nxt;

    // clear first, then set, so a set in the clearing cycle survives
    always_comb begin
        st_nxt = st_r;
        if (readClr || clrAll) begin
            st_nxt.latch = `ISR_EVENT_RESET;
        end
        st_nxt.latch = st_nxt.latch | setBits;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign latch = st_r.latch;

    set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
        (readClr && setBits != 16'h0000) |=> ((latch & $past(setBits)) == $past(setBits)))
        else $error("event lost while clearing");

    bits_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!readClr && !clrAll) |=> ((latch & $past(latch)) == $past(latch)))
        else $error("event bit dropped without clear");

endmodule : isr_event_latch

// >>> verilog/isr_status_sets.sv
// isr_status_sets: standard, operation, measurement and questionable status sets
// assumes: one clock, host commands arrive as one-cycle strobes, conditions are
// synchronous levels and events are one-cycle pulses
`timescale 1ns/10ps
`include "isr_params.svh"

// Operation
// - completion flag only on query, after pending work
// - reading empty output queue sets query error
// - lost data or unresumable scan sets memory error
// - command execution failure sets execution error
// - card mismatch, loss, unsupported set device error
// - local key press sets user request
// - power cycled since last read sets power flag
// - operation set: measuring, trigger wait, filter settled, idle
// - live read-only condition registers for operation, measurement and questionable sets
// - reading beyond range sets overflow bit
// - four limit crossings each set own bit
// - processed reading sets reading available
// - stored count reaching notify count sets notify
// - two or more stored readings set available
// - half full and full bits
// - quarter and three-quarter full bits
// - wrap over old readings sets buffer wrap bit
// - hardware limit bit, any-limit summary bit
// - bad calibration at power-up flagged until recalibrated
// - thermocouple junction and ignored parameter bits
// - error lamp follows questionable conditions
// - events latch, clear on read, clear, power-up
// - enabled events raise each set summary
module isr_status_sets (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cmdValid,
    input wire isr_pkg::isr_cmd_t cmdCode,
    input wire logic opsPending,
    input wire logic talkNoData,
    input wire logic errValid,
    input wire logic [9:0] errCode,
    input wire logic execFail,
    input wire logic localKey,
    input wire logic measuring,
    input wire logic waitTrigger,
    input wire logic filterSettled,
    input wire logic idle,
    input wire logic readingOverflow,
    input wire logic [3:0] limitHit,
    input wire logic hardwareLimit,
    input wire logic readingDone,
    input wire logic [15:0] bufCount,
    input wire logic [15:0] bufSize,
    input wire logic [15:0] notifyCount,
    input wire logic bufWrap,
    input wire logic tempInvalid,
    input wire logic cmdWarning,
    input wire logic calConstInvalid,
    input wire logic calSuccess,
    input wire logic [7:0] stdEnable,
    input wire logic [15:0] operEnable,
    input wire logic [15:0] measEnable,
    input wire logic [15:0] quesEnable,
    output logic respValid,
    output logic [15:0] respData,
    output logic cmdBusy,
    output logic useDefaultCal,
    output logic errorLamp,
    output logic sumStd,
    output logic sumOper,
    output logic sumMeas,
    output logic sumQues
);

    isr_pkg::isr_main_st_t st_r;
    isr_pkg::isr_main_st_t st_nxt;

    logic [15:0] stdLatch;
    logic [15:0] operLatch;
    logic [15:0] measLatch;
    logic [15:0] quesLatch;
    logic [15:0] stdSet;
    logic [15:0] operCondNow;
    logic [15:0] measCondNow;
    logic [15:0] quesCondNow;
    logic cmdTaken;
    logic clrAll;
    logic rdStd;
    logic rdOper;
    logic rdMeas;
    logic rdQues;
    logic completeNow;
    logic [15:0] measSet;

    // true when count has reached the given number of quarters of size
    function automatic logic atQuarters(input logic [15:0] cnt, input logic [15:0] size,
                                        input logic [1:0] quarters);
        logic [17:0] scaled;
        logic [17:0] target;
        scaled = {cnt, 2'b00};
        target = 18'(size) * 18'(quarters);
        atQuarters = (size != 16'h0000) && (scaled >= target);
    endfunction : atQuarters

    // error code falls in one of the listed codes
    function automatic logic codeIs(input logic [9:0] code, input logic [9:0] a,
                                    input logic [9:0] b, input logic [9:0] c);
        codeIs = (code == a) || (code == b) || (code == c);
    endfunction : codeIs

    // commands are ignored while a completion query is still waiting
    assign cmdTaken = cmdValid && !st_r.completeWait;
    assign clrAll = cmdTaken && cmdCode == isr_pkg::CMD_CLEAR_STATUS;
    assign rdStd = cmdTaken && cmdCode == isr_pkg::CMD_READ_STD_EVENT;
    assign rdOper = cmdTaken && cmdCode == isr_pkg::CMD_READ_OPER_EVENT;
    assign rdMeas = cmdTaken && cmdCode == isr_pkg::CMD_READ_MEAS_EVENT;
    assign rdQues = cmdTaken && cmdCode == isr_pkg::CMD_READ_QUES_EVENT;

    // completion is reported only in answer to the query, never on its own
    assign completeNow = !opsPending &&
        (st_r.completeWait || (cmdTaken && cmdCode == isr_pkg::CMD_COMPLETE_QUERY));

    // standard event sources
    always_comb begin
        stdSet = 16'h0000;
        stdSet[`ISR_OPERATION_COMPLETE_FLAG] = completeNow;
        stdSet[`ISR_QUERY_ERROR_FLAG] = talkNoData;
        stdSet[`ISR_BACKED_MEMORY_ERROR_FLAG] = errValid &&
            codeIs(errCode, `ISR_ERR_DATA_LOST, `ISR_ERR_SCAN_RESUME, `ISR_ERR_SCAN_RESUME);
        stdSet[`ISR_EXECUTION_ERROR_FLAG] = execFail;
        stdSet[`ISR_DEVICE_DEPENDENT_ERROR_FLAG] = errValid &&
            codeIs(errCode, `ISR_ERR_SETUP_MISMATCH, `ISR_ERR_CARD_HARDWARE,
                   `ISR_ERR_CARD_UNSUPPORTED);
        stdSet[`ISR_USER_REQUEST_FLAG] = localKey;
        stdSet[`ISR_POWER_ON_FLAG] = st_r.powerOnPend;
    end

    // operation conditions, live
    always_comb begin
        operCondNow = `ISR_COND_RESET;
        operCondNow[`ISR_OPER_MEASURING] = measuring;
        operCondNow[`ISR_OPER_WAIT_TRIGGER] = waitTrigger;
        operCondNow[`ISR_OPER_FILTER_SETTLED] = filterSettled;
        operCondNow[`ISR_OPER_IDLE] = idle;
    end

    // measurement conditions; fill fractions are held low while the buffer size is zero
    always_comb begin
        measCondNow = `ISR_COND_RESET;
        measCondNow[`ISR_READING_OVERFLOW_FLAG] = readingOverflow;
        measCondNow[`ISR_LOW_LIMIT_ONE_FLAG] = limitHit[0];
        measCondNow[`ISR_HIGH_LIMIT_ONE_FLAG] = limitHit[1];
        measCondNow[`ISR_LOW_LIMIT_TWO_FLAG] = limitHit[2];
        measCondNow[`ISR_HIGH_LIMIT_TWO_FLAG] = limitHit[3];
        measCondNow[`ISR_READING_AVAILABLE_FLAG] = readingDone;
        measCondNow[`ISR_BUFFER_NOTIFY_FLAG] = (notifyCount != 16'h0000) &&
            (bufCount >= notifyCount);
        measCondNow[`ISR_BUFFER_AVAILABLE_FLAG] = bufCount >= `ISR_MIN_BUFFERED;
        measCondNow[`ISR_BUFFER_HALF_FLAG] = atQuarters(bufCount, bufSize, 2'd2);
        measCondNow[`ISR_BUFFER_FULL_FLAG] = atQuarters(bufCount, bufSize, 2'd0) &&
            (bufCount >= bufSize);
        measCondNow[`ISR_BUFFER_WRAP_FLAG] = bufWrap;
        measCondNow[`ISR_HARDWARE_LIMIT_FLAG] = hardwareLimit;
        measCondNow[`ISR_BUFFER_QUARTER_FLAG] = atQuarters(bufCount, bufSize, 2'd1);
        measCondNow[`ISR_BUFFER_THREE_QUARTER_FLAG] =
            atQuarters(bufCount, bufSize, 2'd3);
        measCondNow[`ISR_ANY_LIMIT_FLAG] = (|limitHit) || hardwareLimit;
    end

    // questionable conditions; calibration state is held, not a pin level
    always_comb begin
        quesCondNow = `ISR_COND_RESET;
        quesCondNow[`ISR_QUES_TEMPERATURE] = tempInvalid;
        quesCondNow[`ISR_QUES_CALIBRATION] = st_r.calBad;
        quesCondNow[`ISR_QUES_COMMAND_WARNING] = cmdWarning;
    end

    // a fresh limit also marks any-limit, even while another limit already stands
    always_comb begin
        measSet = measCondNow & ~st_r.measCond;
        measSet[`ISR_ANY_LIMIT_FLAG] = measSet[`ISR_ANY_LIMIT_FLAG] ||
            (|measSet[`ISR_HIGH_LIMIT_TWO_FLAG:`ISR_LOW_LIMIT_ONE_FLAG]) ||
            measSet[`ISR_HARDWARE_LIMIT_FLAG];
    end

    // next state: condition copies, power and calibration tracking, answers
    always_comb begin
        st_nxt = st_r;
        st_nxt.operCond = operCondNow;
        st_nxt.measCond = measCondNow;
        st_nxt.quesCond = quesCondNow;
        st_nxt.powerOnPend = 1'b0;
        st_nxt.respValid = 1'b0;
        // strap caught one cycle after release, never under reset itself
        if (!st_r.calSampled) begin
            st_nxt.calSampled = 1'b1;
            st_nxt.calBad = calConstInvalid;
        end else if (calSuccess) begin
            st_nxt.calBad = 1'b0;
        end
        if (completeNow) begin
            st_nxt.completeWait = 1'b0;
            st_nxt.respValid = 1'b1;
            st_nxt.respData = `ISR_COMPLETE_REPLY;
        end else if (cmdTaken) begin
            unique case (cmdCode)
                isr_pkg::CMD_COMPLETE_QUERY: begin
                    st_nxt.completeWait = 1'b1;
                end
                isr_pkg::CMD_READ_STD_EVENT: begin
                    st_nxt.respValid = 1'b1;
                    st_nxt.respData = stdLatch;
                end
                isr_pkg::CMD_READ_OPER_EVENT: begin
                    st_nxt.respValid = 1'b1;
                    st_nxt.respData = operLatch;
                end
                isr_pkg::CMD_READ_MEAS_EVENT: begin
                    st_nxt.respValid = 1'b1;
                    st_nxt.respData = measLatch;
                end
                isr_pkg::CMD_READ_QUES_EVENT: begin
                    st_nxt.respValid = 1'b1;
                    st_nxt.respData = quesLatch;
                end
                isr_pkg::CMD_READ_OPER_COND: begin
                    st_nxt.respValid = 1'b1;
                    st_nxt.respData = st_r.operCond;
                end
                isr_pkg::CMD_READ_MEAS_COND: begin
                    st_nxt.respValid = 1'b1;
                    st_nxt.respData = st_r.measCond;
                end
                isr_pkg::CMD_READ_QUES_COND: begin
                    st_nxt.respValid = 1'b1;
                    st_nxt.respData = st_r.quesCond;
                end
                // clear acts through the latches; preset leaves events alone
                isr_pkg::CMD_CLEAR_STATUS, isr_pkg::CMD_STATUS_PRESET, isr_pkg::CMD_NONE: begin
                end
                default: begin
                end
            endcase
        end
        // summaries look at the latches as they stand
        st_nxt.sumStd = |(stdLatch[7:0] & stdEnable);
        st_nxt.sumOper = |(operLatch & operEnable);
        st_nxt.sumMeas = |(measLatch & measEnable);
        st_nxt.sumQues = |(quesLatch & quesEnable);
        st_nxt.errLamp = |quesCondNow;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '0;
            st_r.powerOnPend <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // sticky event latches; condition sets flag rising transitions
    isr_event_latch u_std (
        .clk_sys(clk_sys),
        .rst(rst),
        .setBits(stdSet),
        .readClr(rdStd),
        .clrAll(clrAll),
        .latch(stdLatch)
    );

    isr_event_latch u_oper (
        .clk_sys(clk_sys),
        .rst(rst),
        .setBits(operCondNow & ~st_r.operCond),
        .readClr(rdOper),
        .clrAll(clrAll),
        .latch(operLatch)
    );

    isr_event_latch u_meas (
        .clk_sys(clk_sys),
        .rst(rst),
        .setBits(measSet),
        .readClr(rdMeas),
        .clrAll(clrAll),
        .latch(measLatch)
    );

    isr_event_latch u_ques (
        .clk_sys(clk_sys),
        .rst(rst),
        .setBits(quesCondNow & ~st_r.quesCond),
        .readClr(rdQues),
        .clrAll(clrAll),
        .latch(quesLatch)
    );

    assign respValid = st_r.respValid;
    assign respData = st_r.respData;
    assign cmdBusy = st_r.completeWait;
    assign useDefaultCal = st_r.calBad;
    assign errorLamp = st_r.errLamp;
    assign sumStd = st_r.sumStd;
    assign sumOper = st_r.sumOper;
    assign sumMeas = st_r.sumMeas;
    assign sumQues = st_r.sumQues;

    complete_only_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(stdLatch[`ISR_OPERATION_COMPLETE_FLAG]) |->
            $past(completeNow) && !$past(opsPending))
        else $error("completion flag without finished query");

    query_error_a: assert property (@(posedge clk_sys) disable iff (rst)
        talkNoData |=> stdLatch[`ISR_QUERY_ERROR_FLAG])
        else $error("query error not latched");

    mem_error_a: assert property (@(posedge clk_sys) disable iff (rst)
        (errValid && (errCode == `ISR_ERR_DATA_LOST || errCode == `ISR_ERR_SCAN_RESUME))
            |=> stdLatch[`ISR_BACKED_MEMORY_ERROR_FLAG])
        else $error("memory error not latched");

    card_error_a: assert property (@(posedge clk_sys) disable iff (rst)
        (errValid && errCode == `ISR_ERR_CARD_HARDWARE)
            |=> stdLatch[`ISR_DEVICE_DEPENDENT_ERROR_FLAG])
        else $error("device error not latched");

    power_flag_a: assert property (@(posedge clk_sys)
        $fell(rst) |=> stdLatch[`ISR_POWER_ON_FLAG])
        else $error("power flag missing after reset");

    buffer_avail_a: assert property (@(posedge clk_sys) disable iff (rst)
        (bufCount >= 16'h0002 && $past(bufCount) < 16'h0002)
            |=> measLatch[`ISR_BUFFER_AVAILABLE_FLAG])
        else $error("buffer available not latched");

    limit_master_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(|limitHit) ##1 !rdMeas && !clrAll |-> measLatch[`ISR_ANY_LIMIT_FLAG])
        else $error("any-limit bit missed");

    lamp_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        (tempInvalid || cmdWarning) |=> errorLamp)
        else $error("error lamp not lit");

    read_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
        rdStd && !completeNow |=> respValid && respData == $past(stdLatch))
        else $error("event read answer wrong");

    summary_std_a: assert property (@(posedge clk_sys) disable iff (rst)
        (|(stdLatch[7:0] & stdEnable)) |=> sumStd)
        else $error("standard summary not raised");

endmodule : isr_status_sets

// >>> dv/isr_host_model.sv
// isr_host_model: remote host that issues one status command at a time
// assumes: clk_sys rising edge, commands taken while cmdBusy is low
`timescale 1ns/10ps

module isr_host_model (
    input wire logic clk_sys,
    input wire logic cmdBusy,
    output logic cmdValid,
    output isr_pkg::isr_cmd_t cmdCode
);
    initial begin
        cmdValid = 1'b0;
        cmdCode = isr_pkg::CMD_NONE;
    end

    // one-cycle strobe; holds off for up to 200 cycles while a completion query waits, since the
    // block drops anything sent then without a word
    task automatic send(input isr_pkg::isr_cmd_t c);
        int n;
        n = 0;
        @(posedge clk_sys);
        while (cmdBusy !== 1'b0 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        cmdValid <= 1'b1;
        cmdCode <= c;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        cmdCode <= isr_pkg::CMD_NONE;
    endtask : send
endmodule : isr_host_model

// >>> dv/isr_status_sets_tb.sv
// isr_status_sets_tb: self-checking bench for the four status register sets
// assumes: isr_pkg compiled first, host model drives the command port
`timescale 1ns/10ps

module isr_status_sets_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic opsPending = 1'b0, calConstInvalid = 1'b1, hwLim = 1'b0;
    logic tempInvalid = 1'b0, cmdWarning = 1'b0;
    logic [7:0] ev = 8'h00, stdEnable = 8'h00;
    logic [3:0] op = 4'h0, lim = 4'h0;
    logic [9:0] errCode = 10'h000;
    logic [15:0] bufCount = 16'h0000, bufSize = 16'h0000, notifyCount = 16'h0000;
    logic [15:0] operEnable = 16'h0000, measEnable = 16'h0000, quesEnable = 16'h0000;
    logic cmdValid, respValid, cmdBusy, useDefaultCal, errorLamp;
    logic sumStd, sumOper, sumMeas, sumQues;
    logic [15:0] respData, sz, expMeas;
    isr_pkg::isr_cmd_t cmdCode;
    logic [15:0] expQ[$];
    int n_mismatch = 0, checks_done = 0, seedV;
    logic [9:0] codes[8] = '{10'h000, 10'h204, 10'h205, 10'h208, 10'h20b, 10'h20c,
                             10'h000, 10'h000};
    logic [7:0] masks[8] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h04, 8'h08};
    logic [15:0] stdExp[8] = '{16'h04, 16'h08, 16'h08, 16'h20, 16'h20, 16'h20,
                               16'h10, 16'h40};

    always #12.5 clk_sys = ~clk_sys;

    isr_host_model host (.clk_sys(clk_sys), .cmdBusy(cmdBusy), .cmdValid(cmdValid),
        .cmdCode(cmdCode));

    isr_status_sets uut (.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .opsPending(opsPending), .talkNoData(ev[0]),
        .errValid(ev[1]), .errCode(errCode), .execFail(ev[2]), .localKey(ev[3]),
        .measuring(op[0]), .waitTrigger(op[1]), .filterSettled(op[2]), .idle(op[3]),
        .readingOverflow(ev[7]), .limitHit(lim), .hardwareLimit(hwLim),
        .readingDone(ev[4]), .bufCount(bufCount), .bufSize(bufSize),
        .notifyCount(notifyCount), .bufWrap(ev[5]), .tempInvalid(tempInvalid),
        .cmdWarning(cmdWarning), .calConstInvalid(calConstInvalid),
        .calSuccess(ev[6]), .stdEnable(stdEnable), .operEnable(operEnable),
        .measEnable(measEnable), .quesEnable(quesEnable), .respValid(respValid),
        .respData(respData), .cmdBusy(cmdBusy), .useDefaultCal(useDefaultCal),
        .errorLamp(errorLamp), .sumStd(sumStd), .sumOper(sumOper),
        .sumMeas(sumMeas), .sumQues(sumQues));

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] e);
        checks_done++;
        if (seen !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, seen);
        end
    endtask : check

    // note the answer expected, then let the host send the command
    task automatic cmd(input isr_pkg::isr_cmd_t c, input logic [15:0] e, input bit r);
        if (r) expQ.push_back(e);
        host.send(c);
    endtask : cmd

    task automatic pulse(input logic [7:0] m);
        @(posedge clk_sys);
        ev <= m;
        @(posedge clk_sys);
        ev <= 8'h00;
    endtask : pulse

    task automatic waitCycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : waitCycles

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    // answers come back in order, so the oldest note belongs to this one
    always @(posedge clk_sys) begin
        if (respValid === 1'b1) begin
            if (expQ.size() == 0) check("answer count", 16'h0001, 16'h0000);
            else check("respData", respData, expQ.pop_front());
        end
    end

    // the tests need well under a thousand cycles
    initial begin
        waitCycles(5000);
        n_mismatch++;
        complete_run();
    end

    initial begin
        seedV = $urandom(32'h3c463d54);
        waitCycles(6);
        rst <= 1'b0;
        waitCycles(4);
        cmd(isr_pkg::CMD_READ_STD_EVENT, 16'h0080, 1);
        cmd(isr_pkg::CMD_READ_STD_EVENT, 16'h0000, 1);
        check("useDefaultCal", {15'h0, useDefaultCal}, 16'h0001);
        cmd(isr_pkg::CMD_READ_QUES_EVENT, 16'h0100, 1);
        pulse(8'h40);
        waitCycles(2);
        check("useDefaultCal", {15'h0, useDefaultCal}, 16'h0000);
        $display("test power_up done");
        // every standard event source but completion and power-on, error codes included
        for (int i = 0; i < 8; i++) begin
            errCode <= codes[i];
            pulse(masks[i]);
            cmd(isr_pkg::CMD_READ_STD_EVENT, stdExp[i], 1);
        end
        errCode <= 10'h1ff;
        pulse(8'h02);
        cmd(isr_pkg::CMD_READ_STD_EVENT, 16'h0000, 1);
        $display("test std_events done");
        stdEnable <= 8'h40;
        pulse(8'h08);
        waitCycles(2);
        check("sumStd", {15'h0, sumStd}, 16'h0001);
        cmd(isr_pkg::CMD_STATUS_PRESET, 16'h0000, 0);
        cmd(isr_pkg::CMD_READ_STD_EVENT, 16'h0040, 1);
        waitCycles(2);
        check("sumStd", {15'h0, sumStd}, 16'h0000);
        pulse(8'h08);
        cmd(isr_pkg::CMD_CLEAR_STATUS, 16'h0000, 0);
        cmd(isr_pkg::CMD_READ_STD_EVENT, 16'h0000, 1);
        // event in the very cycle of the read-clear must survive
        fork
            cmd(isr_pkg::CMD_READ_STD_EVENT, 16'h0000, 1);
            pulse(8'h08);
        join
        cmd(isr_pkg::CMD_READ_STD_EVENT, 16'h0040, 1);
        $display("test clearing done");
        opsPending <= 1'b1;
        cmd(isr_pkg::CMD_COMPLETE_QUERY, 16'h0001, 1);
        waitCycles(1);
        check("cmdBusy", {15'h0, cmdBusy}, 16'h0001);
        waitCycles(5);
        opsPending <= 1'b0;
        cmd(isr_pkg::CMD_READ_STD_EVENT, 16'h0001, 1);
        $display("test completion done");
        operEnable <= 16'h0010;
        op <= 4'hf;
        waitCycles(3);
        check("sumOper", {15'h0, sumOper}, 16'h0001);
        cmd(isr_pkg::CMD_READ_OPER_COND, 16'h0530, 1);
        cmd(isr_pkg::CMD_READ_OPER_EVENT, 16'h0530, 1);
        op <= 4'h7;
        waitCycles(2);
        cmd(isr_pkg::CMD_READ_OPER_COND, 16'h0130, 1);
        $display("test operation done");
        // random buffer size, walked over the quarter boundary to full
        sz = 16'(4 * $urandom_range(100, 8));
        bufSize <= sz;
        notifyCount <= sz;
        measEnable <= 16'h0200;
        bufCount <= sz / 4 - 16'h1;
        waitCycles(2);
        cmd(isr_pkg::CMD_READ_MEAS_COND, 16'h0080, 1);
        bufCount <= sz / 4;
        waitCycles(2);
        cmd(isr_pkg::CMD_READ_MEAS_COND, 16'h1080, 1);
        bufCount <= sz;
        lim <= 4'($urandom_range(15, 1));
        hwLim <= 1'b1;
        pulse(8'hb0);
        expMeas = 16'h7fe1 | {11'h0, lim, 1'b0};
        lim <= 4'h0;
        waitCycles(2);
        check("sumMeas", {15'h0, sumMeas}, 16'h0001);
        cmd(isr_pkg::CMD_READ_MEAS_COND, 16'h7bc0, 1);
        cmd(isr_pkg::CMD_READ_MEAS_EVENT, expMeas, 1);
        // new limit while the hardware limit still stands must mark any-limit again
        lim <= 4'h1;
        waitCycles(2);
        cmd(isr_pkg::CMD_READ_MEAS_EVENT, 16'h4002, 1);
        lim <= 4'h0;
        hwLim <= 1'b0;
        waitCycles(3);
        check("sumMeas", {15'h0, sumMeas}, 16'h0000);
        $display("test measurement done");
        quesEnable <= 16'h4000;
        tempInvalid <= 1'b1;
        cmdWarning <= 1'b1;
        waitCycles(3);
        check("errorLamp", {15'h0, errorLamp}, 16'h0001);
        check("sumQues", {15'h0, sumQues}, 16'h0001);
        cmd(isr_pkg::CMD_READ_QUES_COND, 16'h4010, 1);
        cmd(isr_pkg::CMD_READ_QUES_EVENT, 16'h4010, 1);
        tempInvalid <= 1'b0;
        cmdWarning <= 1'b0;
        waitCycles(3);
        check("errorLamp", {15'h0, errorLamp}, 16'h0000);
        $display("test questionable done");
        waitCycles(3);
        check("answers left", 16'(expQ.size()), 16'h0000);
        complete_run();
    end
endmodule : isr_status_sets_tb
